// >>> rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import port_pins_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [NUM_PINS-1:0] pin_i,
  output logic [NUM_PINS-1:0] level_o
);

  logic [NUM_PINS-1:0] stage1_r;
  logic [NUM_PINS-1:0] stage2_r;
  logic [NUM_PINS-1:0] stage3_r;

  // Stage one feeds only stage two; a bit changes once stages two and three agree.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      level_o <= '0;
    end else if (ce_i) begin
      stage1_r <= pin_i;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      level_o <= (stage2_r & stage3_r) | (level_o & (stage2_r ^ stage3_r));
    end
  end

endmodule
`default_nettype wire

// >>> rtl/port_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
module port_pin_cell (
  input wire logic func_sel_i,
  input wire logic direction_i,
  input wire logic latch_i,
  input wire logic pullup_sel_i,
  input wire logic hyst_en_i,
  input wire logic periph_out_i,
  input wire logic periph_oe_i,
  output logic pad_out_o,
  output logic pad_oe_o,
  output logic pad_pullup_o,
  output logic pad_hyst_o
);

  always_comb begin
    if (func_sel_i) begin
      pad_oe_o = periph_oe_i;
      pad_out_o = periph_out_i & periph_oe_i;
      pad_pullup_o = 1'b0;
    end else begin
      // Undriven pads show a low data line so a never-written latch stays invisible.
      pad_oe_o = direction_i;
      pad_out_o = latch_i & direction_i;
      pad_pullup_o = pullup_sel_i & ~direction_i;
    end
    pad_hyst_o = hyst_en_i | func_sel_i;
  end

endmodule
`default_nettype wire

// >>> rtl/port_pins.sv
// Behaviour
// - Forty-eight pins in six ports of eight, each pin set up on its own.
// - All port registers are eight bits, read/write except sample; bit n is pin n.
// - Ports B and C have no function select and are always general purpose.
// - Function select 0: direction and latch drive the pad, pad feeds sample.
// - In general-purpose mode the input buffer opens only while sample is read.
// - Function select 1: peripheral drives data and enable; input buffer always on.
// - Reset clears every function select register to zero.
// - Direction 0 makes the pin an input, 1 enables the output buffer.
// - Reset clears every direction register to zero.
// - Reading sample returns present pin levels, allowed at any time.
// - Latch supplies the output level; writes change it, reads return last write.
// - Reset leaves the output latch unchanged; undefined after power-up.
// - Pull-up on only in general-purpose mode with buffer off; never in peripheral mode.
// - Reset clears every pull-up select register to zero.
// - Hysteresis applies when its enable bit is set or peripheral mode selected.
// - With latch zero, direction 1 pulls the pin low and 0 floats it.
`timescale 1ns/1ps
`default_nettype none
module port_pins
  import port_pins_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [PORT_WIDTH-1:0] bus_wdata_i,
  output logic [PORT_WIDTH-1:0] bus_rdata_o,
  output logic bus_rvalid_o,
  output logic bus_err_o,
  input wire logic [NUM_PINS-1:0] pin_in_i,
  output logic [NUM_PINS-1:0] pin_out_o,
  output logic [NUM_PINS-1:0] pin_oe_o,
  output logic [NUM_PINS-1:0] pin_pullup_o,
  output logic [NUM_PINS-1:0] pin_hyst_o,
  output logic [NUM_PINS-1:0] pin_in_en_o,
  input wire logic [NUM_PINS-1:0] periph_out_i,
  input wire logic [NUM_PINS-1:0] periph_oe_i,
  output logic [NUM_PINS-1:0] periph_in_o,
  output logic [NUM_PINS-1:0] periph_sel_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic [PORT_SEL_W-1:0] acc_port;
  logic [REG_SEL_W-1:0] acc_reg;
  logic port_valid;
  logic reg_valid;
  logic acc_hit;
  logic wr_go;
  logic rd_go;

  assign acc_port = bus_addr_i[ADDR_W-1:REG_SEL_W];
  assign acc_reg = bus_addr_i[REG_SEL_W-1:0];
  assign port_valid = (acc_port <= PORT_I);
  // Ports without a function select answer that offset as unmapped.
  always_comb begin
    case (acc_reg)
      REG_FUNC_SEL: begin
        reg_valid = (acc_port != PORT_B) && (acc_port != PORT_C);
      end
      REG_DIRECTION, REG_PIN_SAMPLE, REG_OUTPUT_LATCH, REG_PULLUP_SEL, REG_HYST_EN: begin
        reg_valid = 1'b1;
      end
      default: begin
        reg_valid = 1'b0;
      end
    endcase
  end
  assign acc_hit = port_valid && reg_valid;
  assign wr_go = ce_i && bus_wr_i && acc_hit;
  assign rd_go = ce_i && bus_rd_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser.

  logic [NUM_PINS-1:0] pin_level;

  pin_sync u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(pin_in_i),
    .level_o(pin_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Per-port register file and pin cells.

  logic [PORT_WIDTH-1:0] func_sel_r [NUM_PORTS];
  logic [PORT_WIDTH-1:0] direction_r [NUM_PORTS];
  logic [PORT_WIDTH-1:0] latch_r [NUM_PORTS];
  logic [PORT_WIDTH-1:0] pullup_sel_r [NUM_PORTS];
  logic [PORT_WIDTH-1:0] hyst_en_r [NUM_PORTS];
  logic [PORT_WIDTH-1:0] sample_r [NUM_PORTS];
  logic [NUM_PORTS-1:0] sample_read;
  logic [PORT_WIDTH-1:0] port_rd [NUM_PORTS];
  logic [NUM_PINS-1:0] cell_out;
  logic [NUM_PINS-1:0] cell_oe;
  logic [NUM_PINS-1:0] cell_pullup;
  logic [NUM_PINS-1:0] cell_hyst;
  logic [NUM_PINS-1:0] sel_flat;

  genvar gp;
  genvar gb;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      localparam logic [2:0] PORT_ID = 3'(gp);
      localparam bit HAS_FUNC = (PORT_ID != PORT_B) && (PORT_ID != PORT_C);
      logic sel_port;
      logic wr_dir;
      logic wr_latch;
      logic wr_pullup;
      logic wr_hyst;
      logic [PORT_WIDTH-1:0] rd_byte;

      assign sel_port = (acc_port == PORT_ID);
      assign sample_read[gp] = bus_rd_i && sel_port && (acc_reg == REG_PIN_SAMPLE);

      // One strobe per register; a write to the sample offset raises none of them.
      assign wr_dir = wr_go && sel_port && (acc_reg == REG_DIRECTION);
      assign wr_latch = wr_go && sel_port && (acc_reg == REG_OUTPUT_LATCH);
      assign wr_pullup = wr_go && sel_port && (acc_reg == REG_PULLUP_SEL);
      assign wr_hyst = wr_go && sel_port && (acc_reg == REG_HYST_EN);

      if (HAS_FUNC) begin : g_func
        logic wr_func;

        assign wr_func = wr_go && sel_port && (acc_reg == REG_FUNC_SEL);
        always_ff @(posedge sys_clk_i) begin
          if (rst_i) begin
            func_sel_r[gp] <= FUNC_SEL_RST;
          end else if (wr_func) begin
            func_sel_r[gp] <= bus_wdata_i;
          end
        end
      end else begin : g_nofunc
        assign func_sel_r[gp] = FUNC_SEL_RST;
      end

      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          direction_r[gp] <= DIRECTION_RST;
        end else if (wr_dir) begin
          direction_r[gp] <= bus_wdata_i;
        end
      end

      // The latch has no reset branch: its content survives a device reset.
      always_ff @(posedge sys_clk_i) begin
        if (wr_latch) begin
          latch_r[gp] <= bus_wdata_i;
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          pullup_sel_r[gp] <= PULLUP_SEL_RST;
        end else if (wr_pullup) begin
          pullup_sel_r[gp] <= bus_wdata_i;
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          hyst_en_r[gp] <= HYST_EN_RST;
        end else if (wr_hyst) begin
          hyst_en_r[gp] <= bus_wdata_i;
        end
      end

      // Sample tracks the synchronised pins every enabled cycle; bus writes never reach it.
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          sample_r[gp] <= SAMPLE_RST;
        end else if (ce_i) begin
          sample_r[gp] <= pin_level[gp*PORT_WIDTH +: PORT_WIDTH];
        end
      end

      // Each port offers its own read byte; the bus mux below only picks the port.
      always_comb begin
        case (acc_reg)
          REG_FUNC_SEL: begin
            rd_byte = func_sel_r[gp];
          end
          REG_DIRECTION: begin
            rd_byte = direction_r[gp];
          end
          REG_PIN_SAMPLE: begin
            rd_byte = sample_r[gp];
          end
          REG_OUTPUT_LATCH: begin
            rd_byte = latch_r[gp];
          end
          REG_PULLUP_SEL: begin
            rd_byte = pullup_sel_r[gp];
          end
          REG_HYST_EN: begin
            rd_byte = hyst_en_r[gp];
          end
          default: begin
            rd_byte = READ_ZERO;
          end
        endcase
      end
      assign port_rd[gp] = rd_byte;

      for (gb = 0; gb < PORT_WIDTH; gb++) begin : g_bit
        localparam int PIN = gp * PORT_WIDTH + gb;

        port_pin_cell u_cell (
          .func_sel_i(func_sel_r[gp][gb]),
          .direction_i(direction_r[gp][gb]),
          .latch_i(latch_r[gp][gb]),
          .pullup_sel_i(pullup_sel_r[gp][gb]),
          .hyst_en_i(hyst_en_r[gp][gb]),
          .periph_out_i(periph_out_i[PIN]),
          .periph_oe_i(periph_oe_i[PIN]),
          .pad_out_o(cell_out[PIN]),
          .pad_oe_o(cell_oe[PIN]),
          .pad_pullup_o(cell_pullup[PIN]),
          .pad_hyst_o(cell_hyst[PIN])
        );

        assign sel_flat[PIN] = func_sel_r[gp][gb];
        // Peripheral pins keep the buffer open; general pins open it only while their port's sample register is read.
        assign pin_in_en_o[PIN] = func_sel_r[gp][gb] | sample_read[gp];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Pad drivers.

  // Pad controls except the input enable are registered to keep glitches off the pins; this costs one cycle.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_oe_o <= '0;
    end else if (ce_i) begin
      pin_oe_o <= cell_oe;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_out_o <= '0;
    end else if (ce_i) begin
      pin_out_o <= cell_out;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_pullup_o <= '0;
    end else if (ce_i) begin
      pin_pullup_o <= cell_pullup;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_hyst_o <= '0;
    end else if (ce_i) begin
      pin_hyst_o <= cell_hyst;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      periph_sel_o <= '0;
    end else if (ce_i) begin
      periph_sel_o <= sel_flat;
    end
  end

  // Peripherals see the synchronised level only while their function is selected.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      periph_in_o <= '0;
    end else if (ce_i) begin
      periph_in_o <= pin_level & sel_flat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path.

  logic [PORT_WIDTH-1:0] rd_mux;
  logic [PORT_WIDTH-1:0] rdata_nxt;
  logic [PORT_WIDTH-1:0] rdata_r;
  logic rvalid_r;
  logic err_r;
  logic unmapped_acc;
  logic sample_wr;

  always_comb begin
    rd_mux = READ_ZERO;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (acc_port == 3'(p)) begin
        rd_mux = port_rd[p];
      end
    end
    rdata_nxt = acc_hit ? rd_mux : READ_ZERO;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_r <= READ_ZERO;
    end else if (rd_go) begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rvalid_r <= 1'b0;
    end else if (ce_i) begin
      rvalid_r <= bus_rd_i;
    end
  end

  // Error flags an unmapped access or a write aimed at a sample register.
  assign unmapped_acc = (bus_rd_i || bus_wr_i) && !acc_hit;
  assign sample_wr = bus_wr_i && acc_hit && (acc_reg == REG_PIN_SAMPLE);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      err_r <= 1'b0;
    end else if (ce_i) begin
      err_r <= unmapped_acc || sample_wr;
    end
  end

  assign bus_rdata_o = rdata_r;
  assign bus_rvalid_o = rvalid_r;
  assign bus_err_o = err_r;

endmodule
`default_nettype wire

// >>> rtl/port_pins_pkg.sv
package port_pins_pkg;

  localparam int NUM_PORTS = 6;
  localparam int PORT_WIDTH = 8;
  localparam int NUM_PINS = NUM_PORTS * PORT_WIDTH;
  localparam int ADDR_W = 6;
  localparam int REG_SEL_W = 3;
  localparam int PORT_SEL_W = 3;

  // Port index order as seen on the address bus and on the pin vectors.
  localparam logic [2:0] PORT_B = 3'h0;
  localparam logic [2:0] PORT_C = 3'h1;
  localparam logic [2:0] PORT_F = 3'h2;
  localparam logic [2:0] PORT_G = 3'h3;
  localparam logic [2:0] PORT_L = 3'h4;
  localparam logic [2:0] PORT_I = 3'h5;

  // Byte address = port index * 8 + register offset.
  localparam logic [2:0] REG_FUNC_SEL = 3'h0;
  localparam logic [2:0] REG_DIRECTION = 3'h1;
  localparam logic [2:0] REG_PIN_SAMPLE = 3'h2;
  localparam logic [2:0] REG_OUTPUT_LATCH = 3'h3;
  localparam logic [2:0] REG_PULLUP_SEL = 3'h4;
  localparam logic [2:0] REG_HYST_EN = 3'h5;

  localparam logic [7:0] FUNC_SEL_RST = 8'h00;
  localparam logic [7:0] DIRECTION_RST = 8'h00;
  localparam logic [7:0] PULLUP_SEL_RST = 8'h00;
  localparam logic [7:0] HYST_EN_RST = 8'h00;
  localparam logic [7:0] SAMPLE_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

endpackage

// >>> verification/general_purpose_port_pins_bench.sv
`timescale 1ns/1ps
`default_nettype none
module general_purpose_port_pins_bench;
  import port_pins_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [5:0] bus_addr_i = 6'h00;
  logic bus_wr_i = 1'b0;
  logic bus_rd_i = 1'b0;
  logic [7:0] bus_wdata_i = 8'h00;
  logic [7:0] bus_rdata_o;
  logic bus_rvalid_o, bus_err_o;
  logic [47:0] pin_in_i, pin_out_o, pin_oe_o, pin_pullup_o, pin_hyst_o, pin_in_en_o;
  logic [47:0] periph_out_i = '0;
  logic [47:0] periph_oe_i = '0;
  logic [47:0] periph_in_o, periph_sel_o;
  logic [47:0] ext = '0;
  logic [47:0] ext_en = '0;
  logic [31:0] s = 32'h000115D3;
  logic [7:0] sh [6][8];
  int ord [5] = '{3, 1, 4, 5, 0};
  int error_cnt = 0;
  int num_checks = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  port_pins u_port_pins (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .bus_addr_i(bus_addr_i),
    .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i),
    .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o),
    .bus_rvalid_o(bus_rvalid_o),
    .bus_err_o(bus_err_o),
    .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o),
    .pin_pullup_o(pin_pullup_o),
    .pin_hyst_o(pin_hyst_o),
    .pin_in_en_o(pin_in_en_o),
    .periph_out_i(periph_out_i),
    .periph_oe_i(periph_oe_i),
    .periph_in_o(periph_in_o),
    .periph_sel_o(periph_sel_o)
  );
  pad_partner u_pad_partner (.sys_clk_i(sys_clk_i), .out_i(pin_out_o), .oe_i(pin_oe_o),
    .pu_i(pin_pullup_o), .ext_i(ext), .ext_en_i(ext_en), .lvl_o(pin_in_i));
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [47:0] fld(int o);
    for (int p = 0; p < 6; p++) fld[p*8+:8] = sh[p][o];
  endfunction
  // Pad enable, data and pull-up expected from the shadow registers and the peripherals.
  function automatic void pad_exp(output logic [47:0] oe, output logic [47:0] ou,
    output logic [47:0] pu);
    logic [47:0] f;
    logic [47:0] d;
    f = fld(0);
    d = fld(1);
    oe = (f & periph_oe_i) | (~f & d);
    ou = (f & periph_out_i & periph_oe_i) | (~f & d & fld(3));
    pu = fld(4) & ~f & ~d;
  endfunction
  task automatic chk(logic [47:0] g, logic [47:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(int p, int o, logic [7:0] d, logic e);
    @(posedge sys_clk_i);
    #1;
    bus_addr_i = 6'(p * 8 + o);
    bus_wdata_i = d;
    bus_wr_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    bus_wr_i = 1'b0;
    chk(48'(bus_err_o), 48'(e));
  endtask
  task automatic rd(int p, int o, output logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    bus_addr_i = 6'(p * 8 + o);
    bus_rd_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    bus_rd_i = 1'b0;
    d = bus_rvalid_o ? bus_rdata_o : 8'hXX;
  endtask
  // The latch has no reset, so it is only compared once software has written it.
  task automatic regchk(logic l);
    logic [7:0] v;
    for (int p = 0; p < 6; p++)
      for (int o = 0; o < 6; o++)
        if (o != 2 && (o != 3 || l)) begin
          rd(p, o, v);
          chk(48'(v), 48'(sh[p][o]));
        end
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] v;
    logic [47:0] f, oe, ou, pu, lv, m;
    for (int r = 0; r < 3; r++) begin
      rst_i = 1'b1;
      // Peripherals stay idle until software has handed them their pins.
      periph_out_i = '0;
      periph_oe_i = '0;
      repeat (20) @(posedge sys_clk_i);
      #1;
      rst_i = 1'b0;
      for (int p = 0; p < 6; p++)
        for (int o = 0; o < 6; o++) if (o != 3) sh[p][o] = 8'h00;
      regchk(r > 0);
      wr(2, 1, 8'hFF, 1'b0);
      ext = 48'({rnd(), rnd()});
      ext_en = 48'({rnd(), rnd()});
      for (int p = 0; p < 6; p++)
        foreach (ord[i]) begin
          v = 8'(rnd());
          wr(p, ord[i], v, ord[i] == 0 && p < 2);
          if (ord[i] != 0 || p > 1) sh[p][ord[i]] = v;
        end
      periph_out_i = 48'({rnd(), rnd()});
      periph_oe_i = 48'({rnd(), rnd()});
      for (int p = 0; p < 6; p++) wr(p, 2, 8'(rnd()), 1'b1);
      wr(6, 0, 8'h5A, 1'b1);
      // With the clock enable low the write is dropped and the error flag holds.
      ce_i = 1'b0;
      wr(3, 1, ~sh[3][1], 1'b1);
      ce_i = 1'b1;
      regchk(1'b1);
      repeat (10) @(posedge sys_clk_i);
      #1;
      f = fld(0);
      pad_exp(oe, ou, pu);
      lv = (oe & ou) | (~oe & ext_en & ext) | (~oe & ~ext_en & pu);
      m = oe | ext_en | pu;
      chk(pin_oe_o, oe);
      chk(pin_out_o, ou);
      chk(pin_pullup_o, pu);
      chk(pin_hyst_o, fld(5) | f);
      chk(periph_sel_o, f);
      chk(periph_in_o & m, lv & f & m);
      for (int p = 0; p < 6; p++) begin
        rd(p, 2, v);
        chk(48'(v & m[p*8+:8]), 48'(lv[p*8+:8] & m[p*8+:8]));
      end
    end
    close_out();
  end
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    error_cnt++;
    close_out();
  end
endmodule
bind port_pins port_pins_monitor u_port_pins_monitor (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .ce_i(ce_i),
  .bus_addr_i(bus_addr_i),
  .bus_wr_i(bus_wr_i),
  .bus_rd_i(bus_rd_i),
  .bus_wdata_i(bus_wdata_i),
  .bus_rvalid_o(bus_rvalid_o),
  .bus_err_o(bus_err_o),
  .pin_oe_o(pin_oe_o),
  .pin_pullup_o(pin_pullup_o),
  .pin_in_en_o(pin_in_en_o),
  .periph_sel_o(periph_sel_o)
);
`default_nettype wire

// >>> verification/pad_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pad_partner (
  input wire logic sys_clk_i,
  input wire logic [47:0] out_i,
  input wire logic [47:0] oe_i,
  input wire logic [47:0] pu_i,
  input wire logic [47:0] ext_i,
  input wire logic [47:0] ext_en_i,
  output logic [47:0] lvl_o
);
  logic [47:0] flt_r = '0;
  // A pad nobody drives must not look stable, so it toggles every cycle.
  always @(posedge sys_clk_i) flt_r <= ~flt_r;
  assign lvl_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i)
    | (~oe_i & ~ext_en_i & (pu_i | flt_r));
endmodule
`default_nettype wire

// >>> verification/port_pins_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module port_pins_monitor
  import port_pins_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [PORT_WIDTH-1:0] bus_wdata_i,
  input wire logic bus_rvalid_o,
  input wire logic bus_err_o,
  input wire logic [NUM_PINS-1:0] pin_oe_o,
  input wire logic [NUM_PINS-1:0] pin_pullup_o,
  input wire logic [NUM_PINS-1:0] pin_in_en_o,
  input wire logic [NUM_PINS-1:0] periph_sel_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_dir_f_all;
    ce_i && bus_wr_i && bus_addr_i == {PORT_F, REG_DIRECTION} && bus_wdata_i == 8'hFF;
  endsequence
  sequence s_quiet_f;
    ce_i && !bus_wr_i && periph_sel_o[23:16] == 8'h00;
  endsequence
  a_dir_drives: assert property (s_dir_f_all ##1 s_quiet_f |=> pin_oe_o[23:16] == 8'hFF)
    else $error("direction write did not enable drivers");
  a_pu_tristate: assert property ((pin_pullup_o & pin_oe_o) == '0)
    else $error("pull-up on while driving");
  a_inen_idle: assert property (!bus_rd_i |-> pin_in_en_o[15:0] == 16'h0000)
    else $error("input buffer open without a read");
  a_inen_read: assert property (bus_rd_i && bus_addr_i == {PORT_C, REG_PIN_SAMPLE}
    |-> pin_in_en_o[15:0] == 16'hFF00)
    else $error("input buffer not opened for its read");
  a_rd_valid: assert property (ce_i && bus_rd_i && bus_addr_i[2:0] == REG_PIN_SAMPLE
    |=> bus_rvalid_o && !bus_err_o)
    else $error("sample read not answered");
  a_wr_sample_err: assert property (ce_i && bus_wr_i && bus_addr_i[2:0] == REG_PIN_SAMPLE
    |=> bus_err_o)
    else $error("sample write not refused");
  a_wr_bc_err: assert property (ce_i && bus_wr_i && bus_addr_i[5:4] == 2'h0
    && bus_addr_i[2:0] == REG_FUNC_SEL |=> bus_err_o)
    else $error("function select write on B or C not refused");
  a_rst_clear: assert property ($fell(rst_i)
    |-> pin_oe_o == '0 && pin_pullup_o == '0 && periph_sel_o == '0)
    else $error("pads not cleared by reset");
endmodule
`default_nettype wire
